// [logic/glc_counter.sv]
// gated limit event counter with ahb-lite register slave
// assumes one 10 mhz clock; field pins are asynchronous and get synchronised here
//
// Notes on behaviour
// - once, no direction: overflow closes gate, count held at that limit
// - once, up: reaching high limit reloads load value and closes gate
// - up direction: high limit set by software; load value resets to zero
// - once, down: reaching zero reloads load value and closes gate
// - down direction: low limit zero; load value taken from high limit write
// - periodic, no direction: overflow at full range reloads and keeps counting
// - periodic, up or down: reaching limit reloads, gate stays open
// - once, no direction, with interrupting gate: reopening keeps the limit value
// - input function: plain, hardware gate, latch or synchronisation
// - two outputs: plain, at least, at most, pulse; output one also window
// - load, count, compares and output settings writable during operation
// - hardware gate input level may be inverted
// - input filter rejects pulses shorter than configured length
// - filtered input level reported in status
// - software gate opens on rising control bit, closes when bit cleared
// - hardware gate opens on input rise, closes on input fall
// - internal gate is software and hardware gate; shown in status
// - canceling gate restarts from load value; interrupting resumes
// - software-only gate: open resumes or reloads per configuration
// - isochronous: gate opens at next output instant; count sampled at input instant
// - both gates: software open resumes; hardware open per configuration
// - isochronous with hardware gate: counting starts when hardware gate opens
// - count range is 32-bit signed
// - direct load replaces count now; staged load used at events only
`timescale 1ns/1ps
`include "glc_cfg.svh"

module glc_counter
    import glc_pkg::*;
#(
    parameter int FILT_W = 8
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // field pins
    input  wire logic        count_up_pin,
    input  wire logic        count_down_pin,
    input  wire logic        aux_input_pin,
    input  wire logic        iso_out_pin,
    input  wire logic        iso_in_pin,
    output logic             physical_output
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_raw;
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] prev_reg;
    logic [4:0] pin_rise;

    assign pin_raw  = {iso_in_pin, iso_out_pin, aux_input_pin, count_down_pin, count_up_pin};
    assign pin_rise = sync2_reg & ~prev_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg  <= 5'h00;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    glc_bus_t    bus_reg;
    logic        wr_pend_reg;
    logic [7:0]  addr_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] hilim_reg;
    logic [31:0] staged_reg;
    logic [31:0] cmp1_reg;
    logic [31:0] cmp2_reg;
    logic [31:0] outset_reg;
    logic [FILT_W-1:0] filt_len_reg;
    logic [31:0] count_reg;
    logic [31:0] fb_count_reg;
    logic [31:0] latch_reg;
    logic [3:0]  status;
    logic [31:0] rd_mux;
    logic        acc;
    logic        wr_direct;

    assign acc       = hsel & htrans[1] & hready;
    assign wr_direct = wr_pend_reg && (addr_reg == `GLC_OFF_DIRECT);

    // reads take one wait state so that hrdata comes from a flop
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bus_reg     <= GLC_BUS_IDLE;
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hreadyout   <= 1'b1;
            hrdata      <= `GLC_ZERO;
            hresp       <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= acc & hwrite;
            if (acc)
                addr_reg <= haddr[7:0];
            case (bus_reg)
                GLC_BUS_IDLE:
                begin
                    if (acc && !hwrite)
                    begin
                        bus_reg   <= GLC_BUS_READ;
                        hreadyout <= 1'b0;
                    end
                end
                default:
                begin
                    hrdata    <= rd_mux;
                    hreadyout <= 1'b1;
                    bus_reg   <= GLC_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        if (addr_reg == `GLC_OFF_CTRL)
            rd_mux = ctrl_reg;
        else if (addr_reg == `GLC_OFF_HILIM)
            rd_mux = hilim_reg;
        else if (addr_reg == `GLC_OFF_STAGED)
            rd_mux = staged_reg;
        else if (addr_reg == `GLC_OFF_CMP1)
            rd_mux = cmp1_reg;
        else if (addr_reg == `GLC_OFF_CMP2)
            rd_mux = cmp2_reg;
        else if (addr_reg == `GLC_OFF_OUTSET)
            rd_mux = outset_reg;
        else if (addr_reg == `GLC_OFF_FILTER)
            rd_mux = {{(32-FILT_W){1'b0}}, filt_len_reg};
        else if (addr_reg == `GLC_OFF_COUNT)
            rd_mux = fb_count_reg;
        else if (addr_reg == `GLC_OFF_STATUS)
            rd_mux = {28'h0000000, status};
        else if (addr_reg == `GLC_OFF_LATCH)
            rd_mux = latch_reg;
        else
            rd_mux = `GLC_ZERO;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    glc_mode_t mode;
    glc_dir_t  dir;
    glc_difn_t difn;
    logic      sw_bit;
    logic      gint;
    logic      iso_en;
    logic      hw_used;

    assign sw_bit  = ctrl_reg[`GLC_B_SWGATE];
    assign mode    = glc_mode_t'(ctrl_reg[`GLC_B_MODE +: 2]);
    assign dir     = glc_dir_t'(ctrl_reg[`GLC_B_DIR +: 2]);
    assign gint    = ctrl_reg[`GLC_B_GINT];
    assign difn    = glc_difn_t'(ctrl_reg[`GLC_B_DIFN +: 2]);
    assign iso_en  = ctrl_reg[`GLC_B_ISO];
    assign hw_used = (difn == GLC_DI_HWGATE);

    // all of these stay writable while counting runs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_reg     <= `GLC_ZERO;
            hilim_reg    <= `GLC_CNT_MAX;
            staged_reg   <= `GLC_ZERO;
            cmp1_reg     <= `GLC_ZERO;
            cmp2_reg     <= `GLC_ZERO;
            outset_reg   <= `GLC_ZERO;
            filt_len_reg <= FILT_W'(`GLC_FILT_RST);
        end
        else if (wr_pend_reg)
        begin
            if (addr_reg == `GLC_OFF_CTRL)
                ctrl_reg <= hwdata;
            else if (addr_reg == `GLC_OFF_HILIM)
            begin
                hilim_reg <= hwdata;
                if (dir == GLC_DIR_DOWN)
                    staged_reg <= hwdata;
            end
            else if (addr_reg == `GLC_OFF_STAGED)
                staged_reg <= hwdata;
            else if (addr_reg == `GLC_OFF_CMP1)
                cmp1_reg <= hwdata;
            else if (addr_reg == `GLC_OFF_CMP2)
                cmp2_reg <= hwdata;
            else if (addr_reg == `GLC_OFF_OUTSET)
                outset_reg <= hwdata;
            else if (addr_reg == `GLC_OFF_FILTER)
                filt_len_reg <= hwdata[FILT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // input filter and edges
    // ------------------------------------------------------------
    logic              di_filt_reg;
    logic              di_eff_prev_reg;
    logic [FILT_W-1:0] filt_cnt_reg;
    logic              di_eff;
    logic              di_rise;
    logic              di_fall;

    // a level must stay stable for filt_len + 1 cycles, so short pulses die here
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            di_filt_reg  <= 1'b0;
            filt_cnt_reg <= '0;
        end
        else if (!ctrl_reg[`GLC_B_FILT] || sync2_reg[2] == di_filt_reg)
        begin
            di_filt_reg  <= sync2_reg[2];
            filt_cnt_reg <= '0;
        end
        else if (filt_cnt_reg >= filt_len_reg)
        begin
            di_filt_reg  <= sync2_reg[2];
            filt_cnt_reg <= '0;
        end
        else
            filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end

    assign di_eff  = di_filt_reg ^ (hw_used & ctrl_reg[`GLC_B_DIINV]);
    assign di_rise = di_eff & ~di_eff_prev_reg;
    assign di_fall = ~di_eff & di_eff_prev_reg;

    // ------------------------------------------------------------
    // gates
    // ------------------------------------------------------------
    logic sw_prev_reg;
    logic sw_arm_reg;
    logic software_gate_bit_reg;
    logic hw_gate_reg;
    logic hw_prev_reg;
    logic gate_prev_reg;
    logic sw_open_ev;
    logic gate_now;
    logic open_load;
    logic close_ev;
    logic out_rise;

    assign out_rise   = pin_rise[3];
    // isochronous: the rising bit only arms, the output instant opens
    assign sw_open_ev = iso_en ? (sw_arm_reg & out_rise) : (sw_bit & ~sw_prev_reg);
    assign gate_now   = software_gate_bit_reg & (~hw_used | hw_gate_reg);
    // reopening via software while hardware was already open never reloads
    assign open_load  = gate_now & ~gate_prev_reg & ~gint
                        & ~(hw_used & hw_prev_reg);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sw_prev_reg     <= 1'b0;
            sw_arm_reg      <= 1'b0;
            software_gate_bit_reg     <= 1'b0;
            hw_gate_reg     <= 1'b0;
            hw_prev_reg     <= 1'b0;
            gate_prev_reg   <= 1'b0;
            di_eff_prev_reg <= 1'b0;
        end
        else
        begin
            sw_prev_reg     <= sw_bit;
            hw_prev_reg     <= hw_gate_reg;
            gate_prev_reg   <= gate_now;
            di_eff_prev_reg <= di_eff;
            if (!sw_bit || sw_open_ev)
                sw_arm_reg <= 1'b0;
            else if (iso_en && !sw_prev_reg)
                sw_arm_reg <= 1'b1;
            if (!sw_bit || close_ev)
                software_gate_bit_reg <= 1'b0;
            else if (sw_open_ev)
                software_gate_bit_reg <= 1'b1;
            if (!hw_used || di_fall)
                hw_gate_reg <= 1'b0;
            else if (di_rise)
                hw_gate_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic        step_up;
    logic        step_dn;
    logic        step;
    logic [31:0] nxt;
    logic [31:0] hi_eff;
    logic [31:0] lo_eff;
    logic        viol;
    logic        reach;
    logic        lim_ev;
    logic        sync_ev;

    assign step_up = pin_rise[0] & ~pin_rise[1] & gate_now;
    assign step_dn = pin_rise[1] & ~pin_rise[0] & gate_now;
    assign step    = step_up | step_dn;
    assign nxt     = step_up ? count_reg + 32'h00000001 : count_reg - 32'h00000001;
    assign hi_eff  = (dir == GLC_DIR_UP) ? hilim_reg : `GLC_CNT_MAX;
    assign lo_eff  = (dir == GLC_DIR_DOWN) ? `GLC_ZERO : `GLC_CNT_MIN;
    assign viol    = (step_up && count_reg == `GLC_CNT_MAX) ||
                     (step_dn && count_reg == `GLC_CNT_MIN);
    assign reach   = (dir == GLC_DIR_UP && step_up && nxt == hi_eff) ||
                     (dir == GLC_DIR_DOWN && step_dn && nxt == lo_eff);
    assign lim_ev  = (mode == GLC_ONCE || mode == GLC_PERIODIC) &&
                     ((dir == GLC_DIR_NONE) ? viol : reach);
    assign close_ev = lim_ev && mode == GLC_ONCE;
    assign sync_ev  = difn == GLC_DI_SYNC && di_rise && software_gate_bit_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_reg <= `GLC_ZERO;
        else if (wr_direct)
            count_reg <= hwdata;
        else if (sync_ev || open_load)
            count_reg <= staged_reg;
        else if (lim_ev)
        begin
            // once without direction parks at the limit, the rest reload
            if (!(mode == GLC_ONCE && dir == GLC_DIR_NONE))
                count_reg <= staged_reg;
        end
        else if (step)
            count_reg <= nxt;
    end

    // latch and isochronous feedback sample
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            latch_reg    <= `GLC_ZERO;
            fb_count_reg <= `GLC_ZERO;
        end
        else
        begin
            if (difn == GLC_DI_LATCH && di_rise)
                latch_reg <= count_reg;
            if (!iso_en || pin_rise[4])
                fb_count_reg <= count_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [1:0] do_reg;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_out
        logic [31:0] cv;
        glc_dofn_t   fn;
        logic        hit;
        logic [7:0]  pcnt_reg;

        assign cv  = (ch == 0) ? cmp1_reg : cmp2_reg;
        assign fn  = (ch == 0) ? glc_dofn_t'(outset_reg[`GLC_B_FN1 +: 3])
                               : glc_dofn_t'({1'b0, outset_reg[`GLC_B_FN2 +: 2]});
        // with a main direction only the approach in that direction counts
        assign hit = step && nxt == cv && (dir == GLC_DIR_NONE ||
                     (dir == GLC_DIR_UP && step_up) || (dir == GLC_DIR_DOWN && step_dn));

        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                do_reg[ch] <= 1'b0;
                pcnt_reg   <= 8'h00;
            end
            else
            begin
                case (fn)
                    GLC_DO_PLAIN:  do_reg[ch] <= outset_reg[`GLC_B_SET1 + ch];
                    GLC_DO_GE:     do_reg[ch] <= $signed(count_reg) >= $signed(cv);
                    GLC_DO_LE:     do_reg[ch] <= $signed(count_reg) <= $signed(cv);
                    GLC_DO_PULSE:
                    begin
                        if (hit)
                        begin
                            do_reg[ch] <= 1'b1;
                            pcnt_reg   <= 8'(`GLC_PULSE_CYC);
                        end
                        else if (pcnt_reg > 8'h01)
                            pcnt_reg <= pcnt_reg - 8'h01;
                        else
                        begin
                            do_reg[ch] <= 1'b0;
                            pcnt_reg   <= 8'h00;
                        end
                    end
                    GLC_DO_SWITCH:
                        do_reg[ch] <= (ch == 0) && $signed(count_reg) >= $signed(cmp1_reg)
                                      && $signed(count_reg) <= $signed(cmp2_reg);
                    default:       do_reg[ch] <= 1'b0;
                endcase
            end
        end
    end

    assign physical_output = do_reg[0];
    assign status = {do_reg[1], do_reg[0], di_filt_reg, gate_now};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_closed_hold;
        !gate_now && !wr_direct && !sync_ev |=> count_reg == $past(count_reg);
    endproperty
    a_closed_hold: assert property (p_closed_hold) else $error("count moved, gate closed");

    property p_once_close;
        close_ev |=> !software_gate_bit_reg && !gate_now;
    endproperty
    a_once_close: assert property (p_once_close) else $error("once limit left gate open");

    property p_once_park;
        close_ev && dir == GLC_DIR_NONE && !wr_direct && !sync_ev && !open_load
            |=> count_reg == $past(count_reg);
    endproperty
    a_once_park: assert property (p_once_park) else $error("once limit did not park");

    property p_periodic;
        lim_ev && mode == GLC_PERIODIC && !wr_direct && !sync_ev
            |=> count_reg == $past(staged_reg) && software_gate_bit_reg == $past(software_gate_bit_reg);
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic reload wrong");

    property p_hw_and;
        hw_used && !hw_gate_reg |-> !gate_now;
    endproperty
    a_hw_and: assert property (p_hw_and) else $error("gate open, hardware closed");

    property p_hw_edge;
        hw_used && di_rise |=> hw_gate_reg ##1 (hw_gate_reg || $past(di_fall || !hw_used));
    endproperty
    a_hw_edge: assert property (p_hw_edge) else $error("hardware gate missed rise");

    property p_direct;
        wr_direct |=> count_reg == $past(hwdata);
    endproperty
    a_direct: assert property (p_direct) else $error("direct load not applied");

    property p_iso_open;
        $rose(software_gate_bit_reg) && $past(iso_en) |-> $past(out_rise);
    endproperty
    a_iso_open: assert property (p_iso_open) else $error("gate opened off instant");

    property p_open_load;
        open_load && !wr_direct |=> count_reg == $past(staged_reg);
    endproperty
    a_open_load: assert property (p_open_load) else $error("open did not reload");

endmodule : glc_counter

// [logic/glc_cfg.svh]
// constants for the gated limit event counter: offsets, fields, resets, timing
// assumes inclusion by the counter module and the bench
`ifndef GLC_CFG_SVH
`define GLC_CFG_SVH
// register byte offsets
`define GLC_OFF_CTRL    8'h00
`define GLC_OFF_HILIM   8'h04
`define GLC_OFF_STAGED  8'h08
`define GLC_OFF_DIRECT  8'h0C
`define GLC_OFF_CMP1    8'h10
`define GLC_OFF_CMP2    8'h14
`define GLC_OFF_OUTSET  8'h18
`define GLC_OFF_FILTER  8'h1C
`define GLC_OFF_COUNT   8'h20
`define GLC_OFF_STATUS  8'h24
`define GLC_OFF_LATCH   8'h28
// control fields
`define GLC_B_SWGATE    0
`define GLC_B_MODE      1
`define GLC_B_DIR       3
`define GLC_B_GINT      5
`define GLC_B_DIFN      6
`define GLC_B_DIINV     8
`define GLC_B_FILT      9
`define GLC_B_ISO       10
// output setting fields
`define GLC_B_FN1       0
`define GLC_B_FN2       3
`define GLC_B_SET1      5
`define GLC_B_SET2      6
// status fields
`define GLC_B_GATE      0
`define GLC_B_DI        1
`define GLC_B_DO1       2
`define GLC_B_DO2       3
// count range and reset values
`define GLC_CNT_MAX     32'h7FFFFFFF
`define GLC_CNT_MIN     32'h80000000
`define GLC_ZERO        32'h00000000
`define GLC_FILT_RST    8'h04
// comparator pulse duration
`define GLC_CLK_MHZ     10
`define GLC_PULSE_US    10
`define GLC_PULSE_CYC   (`GLC_PULSE_US * `GLC_CLK_MHZ)
`endif

// [logic/glc_pkg.sv]
// types for the gated limit event counter
// assumes glc_cfg.svh holds all numeric constants
package glc_pkg;
    typedef enum logic [1:0] {GLC_CONT, GLC_ONCE, GLC_PERIODIC, GLC_MODE_RSV} glc_mode_t;
    typedef enum logic [1:0] {GLC_DIR_NONE, GLC_DIR_UP, GLC_DIR_DOWN, GLC_DIR_RSV} glc_dir_t;
    typedef enum logic [1:0] {GLC_DI_INPUT, GLC_DI_HWGATE, GLC_DI_LATCH, GLC_DI_SYNC} glc_difn_t;
    typedef enum logic [2:0] {GLC_DO_PLAIN, GLC_DO_GE, GLC_DO_LE, GLC_DO_PULSE,
                              GLC_DO_SWITCH, GLC_DO_R5, GLC_DO_R6, GLC_DO_R7} glc_dofn_t;
    typedef enum logic {GLC_BUS_IDLE, GLC_BUS_READ} glc_bus_t;
endpackage : glc_pkg

// [testbench/glc_field_model.sv]
// field side model: produces count pulses on the two count pins
// assumes pins are sampled through a 2-ff synchroniser in the counter
`timescale 1ns/1ps

module glc_field_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // request from bench
    input  wire logic       start,
    input  wire logic       dir_dn,
    input  wire logic [7:0] n,
    output logic            busy,
    // field pins
    output logic            count_up_pin,
    output logic            count_down_pin
);
    logic [7:0] rem_reg;
    logic [2:0] ph_reg;
    logic       dn_reg;

    // 3 cycles high, 3 low: above the 2-high 2-low minimum
    always_ff @(posedge clk)
    begin
        if (!rst_n) begin rem_reg <= 8'h00; ph_reg <= 3'h0; dn_reg <= 1'b0; end
        else if (start) begin rem_reg <= n; ph_reg <= 3'h0; dn_reg <= dir_dn; end
        else if (rem_reg != 8'h00)
        begin
            ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
            if (ph_reg == 3'h5) rem_reg <= rem_reg - 8'h01;
        end
    end

    assign busy           = rem_reg != 8'h00;
    assign count_up_pin   = busy && ph_reg < 3'h3 && !dn_reg;
    assign count_down_pin = busy && ph_reg < 3'h3 && dn_reg;
endmodule : glc_field_model

// [testbench/gated_limit_event_counter_tb.sv]
// self-checking bench: ahb-lite master tasks plus field pin model
// assumes the counter answers reads with one wait state
`timescale 1ns/1ps
`include "glc_cfg.svh"

module gated_limit_event_counter_tb
    import glc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, aux = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, s;
    logic [1:0]  htrans = 2'b00;
    logic hreadyout, hresp, pout, up, dn, busy, start = 1'b0, dir_dn = 1'b0;
    logic [7:0]  n = 8'h00;
    logic        iso_o = 1'b0, iso_i = 1'b0;
    int          mismatches = 0, n_tests = 0;

    always #50 clk = ~clk;

    glc_counter DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .count_up_pin(up),
        .count_down_pin(dn), .aux_input_pin(aux), .iso_out_pin(iso_o), .iso_in_pin(iso_i),
        .physical_output(pout));
    glc_field_model FM (.clk(clk), .rst_n(rst_n), .start(start), .dir_dn(dir_dn), .n(n),
        .busy(busy), .count_up_pin(up), .count_down_pin(dn));

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
        hsel <= 1'b0;
    endtask : ahb

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd_chk

    task pulses(input logic d, input logic [7:0] k);
        @(posedge clk);
        start <= 1'b1; dir_dn <= d; n <= k;
        @(posedge clk);
        start <= 1'b0;
        do @(posedge clk); while (busy === 1'b1);
        repeat (3) @(posedge clk);
    endtask : pulses

    function automatic logic [31:0] cw(logic sw, glc_mode_t m, glc_dir_t d, logic intr,
                                       glc_difn_t f, logic inv);
        return {22'h0, 1'b1, inv, f, intr, d, m, sw};
    endfunction : cw

    task close_out();
        $display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        #(100 * 20000);
        mismatches++;
        close_out();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(31268));
        s = $urandom & 32'h0000FFFF;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`GLC_OFF_HILIM, `GLC_CNT_MAX);
        rd_chk(`GLC_OFF_STAGED, `GLC_ZERO);
        rd_chk(`GLC_OFF_FILTER, {24'h0, `GLC_FILT_RST});
        rd_chk(8'h3C, `GLC_ZERO);
        $display("test reset done");
        ahb(1'b1, `GLC_OFF_STAGED, s);
        ahb(1'b1, `GLC_OFF_CTRL, cw(0, GLC_PERIODIC, GLC_DIR_NONE, 0, GLC_DI_INPUT, 0));
        pulses(1'b0, 8'h03);
        rd_chk(`GLC_OFF_COUNT, `GLC_ZERO);
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_PERIODIC, GLC_DIR_NONE, 0, GLC_DI_INPUT, 0));
        // open reload and feedback copy each take an edge
        repeat (2) @(posedge clk);
        rd_chk(`GLC_OFF_COUNT, s);
        n = 8'h01 + 8'($urandom % 8);
        pulses(1'b0, n);
        rd_chk(`GLC_OFF_COUNT, s + 32'(n));
        rd_chk(`GLC_OFF_STATUS, 32'h1);
        ahb(1'b1, `GLC_OFF_DIRECT, `GLC_CNT_MAX - 32'h1);
        rd_chk(`GLC_OFF_COUNT, `GLC_CNT_MAX - 32'h1);
        pulses(1'b0, 8'h02);
        rd_chk(`GLC_OFF_COUNT, s);
        $display("test periodic done");
        ahb(1'b1, `GLC_OFF_CTRL, cw(0, GLC_ONCE, GLC_DIR_UP, 0, GLC_DI_INPUT, 0));
        ahb(1'b1, `GLC_OFF_HILIM, s + 32'h3);
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_ONCE, GLC_DIR_UP, 0, GLC_DI_INPUT, 0));
        pulses(1'b0, 8'h04);
        rd_chk(`GLC_OFF_COUNT, s);
        rd_chk(`GLC_OFF_STATUS, 32'h0);
        ahb(1'b1, `GLC_OFF_CTRL, cw(0, GLC_ONCE, GLC_DIR_NONE, 1, GLC_DI_INPUT, 0));
        ahb(1'b1, `GLC_OFF_DIRECT, `GLC_CNT_MIN + 32'h1);
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_ONCE, GLC_DIR_NONE, 1, GLC_DI_INPUT, 0));
        rd_chk(`GLC_OFF_COUNT, `GLC_CNT_MIN + 32'h1);
        pulses(1'b1, 8'h03);
        rd_chk(`GLC_OFF_COUNT, `GLC_CNT_MIN);
        ahb(1'b1, `GLC_OFF_CTRL, cw(0, GLC_ONCE, GLC_DIR_NONE, 1, GLC_DI_INPUT, 0));
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_ONCE, GLC_DIR_NONE, 1, GLC_DI_INPUT, 0));
        rd_chk(`GLC_OFF_COUNT, `GLC_CNT_MIN);
        $display("test once done");
        ahb(1'b1, `GLC_OFF_CTRL, cw(0, GLC_PERIODIC, GLC_DIR_DOWN, 0, GLC_DI_INPUT, 0));
        ahb(1'b1, `GLC_OFF_HILIM, 32'h5);
        rd_chk(`GLC_OFF_STAGED, 32'h5);
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_PERIODIC, GLC_DIR_DOWN, 0, GLC_DI_INPUT, 0));
        pulses(1'b1, 8'h05);
        rd_chk(`GLC_OFF_COUNT, 32'h5);
        rd_chk(`GLC_OFF_STATUS, 32'h1);
        $display("test down done");
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_PERIODIC, GLC_DIR_NONE, 1, GLC_DI_HWGATE, 0));
        rd_chk(`GLC_OFF_STATUS, 32'h0);
        @(posedge clk) aux <= 1'b1;
        repeat (2) @(posedge clk);
        aux <= 1'b0;
        rd_chk(`GLC_OFF_STATUS, 32'h0);
        aux <= 1'b1;
        repeat (20) @(posedge clk);
        rd_chk(`GLC_OFF_STATUS, 32'h3);
        ahb(1'b1, `GLC_OFF_CTRL, cw(1, GLC_PERIODIC, GLC_DIR_NONE, 1, GLC_DI_HWGATE, 1));
        repeat (4) @(posedge clk);
        rd_chk(`GLC_OFF_STATUS, 32'h2);
        $display("test hw gate done");
        ahb(1'b1, `GLC_OFF_OUTSET, 32'h20);
        repeat (2) @(posedge clk);
        chk({31'h0, pout}, 32'h1);
        ahb(1'b1, `GLC_OFF_CMP1, 32'h5);
        ahb(1'b1, `GLC_OFF_OUTSET, 32'h11);
        rd_chk(`GLC_OFF_STATUS, 32'h6);
        ahb(1'b1, `GLC_OFF_CMP1, 32'h6);
        repeat (2) @(posedge clk);
        chk({31'h0, pout}, 32'h0);
        $display("test outputs done");
        ahb(1'b1, `GLC_OFF_CTRL, 32'h400 | cw(0, GLC_PERIODIC, GLC_DIR_NONE, 0, GLC_DI_INPUT, 0));
        ahb(1'b1, `GLC_OFF_CTRL, 32'h400 | cw(1, GLC_PERIODIC, GLC_DIR_NONE, 0, GLC_DI_INPUT, 0));
        rd_chk(`GLC_OFF_STATUS, 32'h2);
        iso_o <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`GLC_OFF_STATUS, 32'h3);
        pulses(1'b0, 8'h02);
        rd_chk(`GLC_OFF_COUNT, 32'h5);
        iso_i <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`GLC_OFF_COUNT, 32'h7);
        $display("test iso done");
        close_out();
    end
endmodule : gated_limit_event_counter_tb
